// ==== design/slsoc_consts.vh ====
/*
 * constants for the serial low-side output control block: word size,
 * register reset value, synchroniser reset values and host timing figures.
 * assumes it is included by bare name from the design files.
 */
`ifndef SLSOC_CONSTS_VH
`define SLSOC_CONSTS_VH

`define SLSOC_WORD_BITS        8
`define SLSOC_CNT_BITS         4
`define SLSOC_CTRL_RESET       8'h00
`define SLSOC_CNT_ZERO         4'h0
`define SLSOC_CNT_ONE          4'h1
`define SLSOC_CNT_FULL         4'h8
`define SLSOC_FIRST_BIT        0
`define SLSOC_SYNC_RESET       2'b00
`define SLSOC_SYNC_RESET_1     1'b0

// host timing figures in ns, with the clock period they are held against
`define SLSOC_REF_PERIOD_NS    8
`define SLSOC_T_SEL_RISE_NS    10
`define SLSOC_T_SEL_FALL_NS    80
`define SLSOC_T_PHASE_NS       60
`define SLSOC_T_LAST_DESEL_NS  80
`define SLSOC_T_GAP_NS         170
`define SLSOC_CYC_MIN(ns)      (((ns) + `SLSOC_REF_PERIOD_NS - 1) / `SLSOC_REF_PERIOD_NS)

`endif

// ==== design/slsoc_sync.v ====
/*
 * two flip-flop synchroniser for one asynchronous level.
 * assumes the input is a pin from outside the ref_clk domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "slsoc_consts.vh"

module slsoc_sync (
    input  wire ref_clk,
    input  wire resetn,
    input  wire async_in,
    output wire sync_out
);
    reg [1:0] stage;

    // first stage is read only by the second stage
    always @(posedge ref_clk) begin
        if (!resetn) begin
            stage <= `SLSOC_SYNC_RESET;
        end else begin
            stage <= {stage[0], async_in};
        end
    end

    assign sync_out = stage[1];
endmodule
`default_nettype wire

// ==== design/slsoc_top.v ====
/*
 * serial low-side output control: a write-only serial slave that shifts
 * in one 8-bit word and, on the rising edge of select, copies it into
 * the single output control register driving eight low-side drivers.
 * assumes the host serial clock is slow against ref_clk (125 MHz); all
 * link pins are sampled through two flip-flops and edges found on ref_clk.
 */
// Summary of operation
// - bit one turns output on, zero off
// - one register drives all eight outputs
// - each transfer carries one eight-bit word
// - clock and data ignored while select high
// - select rising copies a shifted word of eight or more bits to register
`timescale 1ns/1ps
`default_nettype none
`include "slsoc_consts.vh"

module slsoc_top (
    input  wire       ref_clk,
    input  wire       resetn,
    input  wire       select_low,
    input  wire       serial_clk,
    input  wire       serial_data,
    input  wire       first_driver_force_on,
    output wire [7:0] low_side_drivers,
    output reg  [7:0] output_switch_control,
    output reg        word_error
);
    // host timing figures in ref_clk cycles, rounded up. the host keeps
    // them; the sampling here only needs each serial clock phase and each
    // select level to last at least two ref_clk cycles, which the 60 ns
    // minimum phase gives with room to spare at 8 ns per cycle.
    // limitation: a host that runs the link faster than that will have
    // edges merged in the synchronisers and its words refused as short.
    // the figures stay here as the reference for anyone retiming the
    // link or moving the block to a slower reference clock.
    localparam integer SEL_RISE_CYC  = `SLSOC_CYC_MIN(`SLSOC_T_SEL_RISE_NS);
    localparam integer SEL_FALL_CYC  = `SLSOC_CYC_MIN(`SLSOC_T_SEL_FALL_NS);
    localparam integer PHASE_CYC     = `SLSOC_CYC_MIN(`SLSOC_T_PHASE_NS);
    localparam integer LAST_DES_CYC  = `SLSOC_CYC_MIN(`SLSOC_T_LAST_DESEL_NS);
    localparam integer GAP_CYC       = `SLSOC_CYC_MIN(`SLSOC_T_GAP_NS);

    // synchronised pins; select is carried inverted, as "selected", so
    // that the synchroniser's all-zero reset matches the idle pin level
    // and no false end-of-word edge follows reset
    wire sel_act_s;
    wire sclk_s;
    wire sdat_s;
    wire force_s;

    reg       sel_act_d;
    reg       sclk_d;
    reg [7:0] shift_word;
    reg [3:0] bit_count;

    // next values of the link state, worked out in one place each
    reg [7:0] next_shift_word;
    reg [3:0] next_bit_count;
    reg [7:0] next_output_switch_control;
    reg       next_word_error;

    wire sclk_rise;
    wire sel_rise;
    wire word_full;

    // driver stage: the pins come from flops so that a change of the
    // register and of the force-on input never glitches a load
    wire [7:0] next_drive;
    reg  [7:0] drive_q;

    // every link pin and the force-on pin cross into ref_clk here.
    // the inverter sits ahead of the first flop, so it adds no hazard.
    // clock and data pass identical stages, so a data bit and the clock
    // edge that qualifies it reach the shift logic in the same cycle.
    // the force-on pin left open is taken as low by the board.
    slsoc_sync u_sync_sel (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .async_in (~select_low),
        .sync_out (sel_act_s)
    );
    slsoc_sync u_sync_clk (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .async_in (serial_clk),
        .sync_out (sclk_s)
    );
    slsoc_sync u_sync_dat (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .async_in (serial_data),
        .sync_out (sdat_s)
    );
    slsoc_sync u_sync_force (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .async_in (first_driver_force_on),
        .sync_out (force_s)
    );

    // delayed copies for edge detection, taken after the synchronisers;
    // both reset to the idle level of their pin
    always @(posedge ref_clk) begin
        if (!resetn) begin
            sel_act_d <= `SLSOC_SYNC_RESET_1;
            sclk_d    <= `SLSOC_SYNC_RESET_1;
        end else begin
            sel_act_d <= sel_act_s;
            sclk_d    <= sclk_s;
        end
    end

    // rising clock counts only while selected; high select masks it
    assign sclk_rise = sclk_s & ~sclk_d & sel_act_s;
    // the select pin rising marks the end of a word
    assign sel_rise  = ~sel_act_s & sel_act_d;
    // eight or more rises make a word; extra rises hold the count at eight
    assign word_full = (bit_count == `SLSOC_CNT_FULL);

    // shift and count: msb first, so the eighth output's bit lands on top.
    // select rising restarts the count so the next word starts clean,
    // whatever was left over from a cut or refused word
    always @* begin
        next_shift_word = shift_word;
        next_bit_count  = bit_count;
        if (sel_rise) begin
            next_bit_count = `SLSOC_CNT_ZERO;
        end else if (sclk_rise) begin
            next_shift_word = {shift_word[6:0], sdat_s};
            if (!word_full) begin
                next_bit_count = bit_count + `SLSOC_CNT_ONE;
            end
        end
    end

    // shift register and bit counter
    always @(posedge ref_clk) begin
        if (!resetn) begin
            shift_word <= `SLSOC_CTRL_RESET;
            bit_count  <= `SLSOC_CNT_ZERO;
        end else begin
            shift_word <= next_shift_word;
            bit_count  <= next_bit_count;
        end
    end

    // load on select rise; a short word is dropped, since latching a
    // misaligned word could switch the wrong loads. a long word keeps its
    // last eight bits, as a plain shift register would. the error flag
    // only moves at the end of a word, so its set and clear never meet
    // in one cycle. select rising and a clock rise cannot coincide, as
    // the clock rise is only counted while selected.
    always @* begin
        next_output_switch_control = output_switch_control;
        next_word_error            = word_error;
        if (sel_rise) begin
            if (word_full) begin
                next_output_switch_control = shift_word;
                next_word_error            = 1'b0;
            end else begin
                next_word_error            = 1'b1;
            end
        end
    end

    // the one control register and the error flag, cleared at reset
    always @(posedge ref_clk) begin
        if (!resetn) begin
            output_switch_control <= `SLSOC_CTRL_RESET;
            word_error            <= 1'b0;
        end else begin
            output_switch_control <= next_output_switch_control;
            word_error            <= next_word_error;
        end
    end

    // per-output drive: bit set turns the driver on; the first output
    // can also be forced on by its dedicated input. the force path does
    // not pass the register, so a later word cannot undo it, and
    // releasing the input hands the output back to its register bit.
    genvar g;
    generate
        for (g = 0; g < `SLSOC_WORD_BITS; g = g + 1) begin : g_drv
            if (g == `SLSOC_FIRST_BIT) begin : g_first
                assign next_drive[g] = output_switch_control[g] | force_s;
            end else begin : g_rest
                assign next_drive[g] = output_switch_control[g];
            end
        end
    endgenerate

    // driver flops: one cycle after the register, trading a cycle of
    // latency for clean pins; reset leaves every load switched off
    always @(posedge ref_clk) begin
        if (!resetn) begin
            drive_q <= `SLSOC_CTRL_RESET;
        end else begin
            drive_q <= next_drive;
        end
    end

    // the pins carry the flopped drive levels
    assign low_side_drivers = drive_q;

endmodule
`default_nettype wire

// ==== tb/slsoc_assertions.sv ====
/* pin checker for slsoc_top; assumes a bind to it and one clock */
`timescale 1ns/1ps
`default_nettype none
module slsoc_assertions (
    input wire logic       ref_clk,
    input wire logic       resetn,
    input wire logic       select_low,
    input wire logic       first_driver_force_on,
    input wire logic [7:0] low_side_drivers,
    input wire logic [7:0] output_switch_control
);
    wire [7:0] drv = low_side_drivers;
    wire [7:0] ctl = output_switch_control;
    wire       frc = first_driver_force_on;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // loads land a few edges after select rises, never mid-word
    sequence s_rose; $past(select_low, 2) && !$past(select_low, 6); endsequence
    property p_up; drv[7:1] == $past(ctl[7:1]); endproperty
    a_up: assert property (p_up) else $error("up");
    property p_on; frc [*5] |-> drv[0]; endproperty
    a_on: assert property (p_on) else $error("on");
    property p_fol; !frc [*5] |-> drv[0] == $past(ctl[0]); endproperty
    a_fol: assert property (p_fol) else $error("fol");
    property p_rst; $rose(resetn) |-> ctl == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("rst");
    property p_ld; $changed(ctl) |-> s_rose; endproperty
    a_ld: assert property (p_ld) else $error("ld");
    property p_drv; $changed(drv[7:1]) |-> s_rose; endproperty
    a_drv: assert property (p_drv) else $error("drv");
    property p_low; !select_low [*6] |-> $stable(ctl); endproperty
    a_low: assert property (p_low) else $error("low");
    property p_idle; select_low [*8] |-> $stable(ctl); endproperty
    a_idle: assert property (p_idle) else $error("idle");
endmodule
`default_nettype wire

// ==== tb/slsoc_host.sv ====
/* host model, serial master; assumes pins move at ref_clk rises */
`timescale 1ns/1ps
`default_nettype none
module slsoc_host (
    input  wire logic ref_clk,
    output var logic  select_low = 1'b1,
    output var logic  serial_clk = 1'b0,
    output var logic  serial_data = 1'b0
);
    // n rises, msb first; sel low clocks with select high
    task send(input logic [7:0] w, input int n, input int ph, input logic sel);
        select_low <= ~sel;
        for (int k = 2 * n; k > 0; k--) begin
            if (k % 2 == 0) serial_data <= w[k/2-1];
            repeat (ph) @(posedge ref_clk);
            serial_clk <= (k % 2 == 0);
        end
        repeat (2 * ph) @(posedge ref_clk);
        {select_low, serial_data} <= {1'b1, ~serial_data}; // no stale bit
        repeat (3 * ph) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
/* bench for slsoc_top; assumes host and checker compiled first */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic       ref_clk = 1'b0, resetn = 1'b0, force_on = 1'b0;
    wire        sel_n, sck, sdi, werr;
    wire  [7:0] drv, ctl;
    int         err_count = 0, n_compared = 0;
    // half a modulation period at the highest rate, in 8 ns cycles
    localparam int PWM_HALF_CYC = 12500;
    // cycles one send of eight bits at phase 8 takes
    localparam int SEND_CYC = 168;
    initial forever #4 ref_clk = ~ref_clk;
    slsoc_host i_host (.ref_clk(ref_clk), .select_low(sel_n), .serial_clk(sck), .serial_data(sdi));
    slsoc_top i_dut (.ref_clk(ref_clk), .resetn(resetn), .select_low(sel_n), .serial_clk(sck),
        .serial_data(sdi), .first_driver_force_on(force_on), .low_side_drivers(drv),
        .output_switch_control(ctl), .word_error(werr));
    // e: expected error flag and drivers; ec: expected register
    task chk(input string s, input logic [8:0] e, input logic [7:0] ec);
        n_compared++;
        if ({werr, drv} !== e) begin
            err_count++;
            $display("MISMATCH %s pins expected %h seen %h", s, e, {werr, drv});
        end
        if (ctl !== ec) begin
            err_count++;
            $display("MISMATCH %s register expected %h seen %h", s, ec, ctl);
        end
    endtask
    // reset pulse: everything clear and no false end of word after it
    task t_reset;
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk("reset", 9'h000, 8'h00);
    endtask
    // bit 0 toggled by rewrites half a period apart, then a mid-run reset
    task t_pwm;
        i_host.send(8'h01, 8, 8, 1'b1);
        chk("pwm on", 9'h001, 8'h01);
        repeat (PWM_HALF_CYC - SEND_CYC) @(posedge ref_clk);
        i_host.send(8'h00, 8, 8, 1'b1);
        chk("pwm off", 9'h000, 8'h00);
        i_host.send(8'ha5, 8, 8, 1'b1);
        chk("mixed", 9'h0a5, 8'ha5);
        t_reset;
    endtask
    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // one-hot words tell outputs and bit order apart
    task t_walk;
        for (int i = 0; i < 8; i++) begin
            i_host.send(8'h01 << i, 8, 8, 1'b1);
            chk("walk", 9'h001 << i, 8'h01 << i);
        end
    endtask
    // short word, deselected clocks, then force on
    task t_refuse;
        i_host.send(8'h3c, 7, 20, 1'b1);
        chk("short", 9'h180, 8'h80);
        i_host.send(8'h3c, 8, 8, 1'b0);
        chk("desel", 9'h180, 8'h80);
        force_on <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk("force", 9'h181, 8'h80);
        force_on <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk("release", 9'h180, 8'h80);
    endtask
    initial begin
        t_reset;
        t_walk;
        t_refuse;
        t_pwm;
        finish_test;
    end
endmodule
bind slsoc_top slsoc_assertions i_chk (.ref_clk(ref_clk), .resetn(resetn),
    .select_low(select_low), .first_driver_force_on(first_driver_force_on),
    .low_side_drivers(low_side_drivers), .output_switch_control(output_switch_control));
`default_nettype wire
